// ===== common/usp_pkg.sv
/*
 Package for the USB suspend and pin control block: timing constants,
 link state encodings and reset values.
 Assumes a single 25 MHz clock.
*/
package usp_pkg;
   // Clock rate
   localparam int CLK_HZ = 25_000_000;
   // Least external reset pulse, in microseconds
   localparam int RST_PULSE_US = 15;
   // Least pulse in cycles, microseconds times whole cycles per microsecond
   localparam int RST_PULSE_CYC = (RST_PULSE_US * (CLK_HZ / 1_000_000));
   // Internal power-on reset stretch in cycles
   localparam int POR_CYC = 32;
   // Number of general-purpose pins
   localparam int GPIO_N = 4;
   // Reset values of active-low outputs
   localparam logic MODEM_OUT_RST = 1'h1;
   localparam logic TXD_IDLE = 1'h1;
   // Device link state
   typedef enum logic [1:0] {
      USP_UNCONF = 2'h0,
      USP_ACTIVE = 2'h1,
      USP_SUSP = 2'h2
   } usp_state_t;
endpackage

// ===== common/usp_sync_if.sv
/*
 Interface carrying W synchronised pins between the pin synchroniser and
 the main block. Assumes both ends share the main clock.
*/
`timescale 1ns/1ps
interface usp_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport syncer (input raw, output sync);
   modport user (output raw, input sync);
endinterface

// ===== logic/usp_sync.sv
/*
 Two-stage synchroniser for pins arriving from outside the clock domain.
 Assumes the raw level is stable long enough to be sampled twice.
*/
`timescale 1ns/1ps
module usp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Pins in, levels out
   usp_sync_if.syncer s
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // First stage feeds only the second
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= s.raw;
         sync_q <= meta_q;
      end
   end
   assign s.sync = sync_q;
endmodule

// ===== logic/usp_top.sv
/*
 Suspend and pin control of a USB to serial bridge: reset pin handling,
 bus power sense, suspend outputs, modem lines, serial lines and
 general-purpose pins. Assumes the USB engine reports suspend, resume,
 bus reset and configuration as one-cycle pulses on this clock, and that
 serial framing lives in the engine behind the txd/rxd bit ports.
*/
`timescale 1ns/1ps
module usp_top
   import usp_pkg::*;
#(
   parameter int NGPIO = usp_pkg::GPIO_N
) (
   // Clock and synchronous reset
   input wire logic clock,
   input wire logic rst,
   // Reset pin, open drain
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe,
   // Bus power sense pin
   input wire logic vbus_i,
   output logic attached,
   // Events from the USB engine
   input wire logic ev_suspend,
   input wire logic ev_resume,
   input wire logic ev_bus_reset,
   input wire logic ev_configured,
   output logic dev_reset,
   // Suspend outputs
   output logic suspend,
   output logic suspend_n,
   output logic suspend_oe,
   // Modem status pins, active low
   input wire logic cts_n_i,
   input wire logic dsr_n_i,
   input wire logic dcd_n_i,
   input wire logic ri_n_i,
   output logic [3:0] modem_status,
   // Modem control requests and pins
   input wire logic rts_req,
   input wire logic dtr_req,
   output logic rts_n_o,
   output logic dtr_n_o,
   // Serial bit lines
   input wire logic tx_bit,
   input wire logic rxd_i,
   output logic txd_o,
   output logic rx_bit,
   // General-purpose pins
   input wire logic [NGPIO-1:0] gpio_dir,
   input wire logic [NGPIO-1:0] gpio_wr,
   input wire logic [NGPIO-1:0] gpio_i,
   output logic [NGPIO-1:0] gpio_o,
   output logic [NGPIO-1:0] gpio_oe,
   output logic [NGPIO-1:0] gpio_rd
);
   import usp_pkg::*;

   localparam int SW = 7 + NGPIO;
   localparam int CW = $clog2(RST_PULSE_CYC + 1);
   localparam int PW = $clog2(POR_CYC + 1);

   usp_sync_if #(.W(SW)) pins ();
   usp_state_t state_q;
   logic [CW-1:0] low_cnt_q;
   logic [PW-1:0] por_cnt_q;
   logic ext_rst_q;
   logic in_reset;
   logic pin_low;

   // All pins from outside pass two flops first
   assign pins.raw = {gpio_i, rxd_i, ri_n_i, dcd_n_i, dsr_n_i, cts_n_i,
      vbus_i, rst_pin_i};
   usp_sync #(.W(SW)) u_sync (
      .clock(clock),
      .rst(rst),
      .s(pins.syncer)
   );
   assign pin_low = ~pins.sync[0];

   // Power-on stretch; pin is pulled low meanwhile
   always_ff @(posedge clock) begin
      if (rst) begin
         por_cnt_q <= '0;
      end else if (por_cnt_q != PW'(POR_CYC)) begin
         por_cnt_q <= por_cnt_q + PW'(1);
      end
   end

   // External pulse must last the least time before it counts
   always_ff @(posedge clock) begin
      if (rst) begin
         low_cnt_q <= '0;
         ext_rst_q <= 1'h0;
      end else if (!pin_low || rst_pin_oe) begin
         low_cnt_q <= '0;
         ext_rst_q <= 1'h0;
      end else if (low_cnt_q != CW'(RST_PULSE_CYC - 1)) begin
         low_cnt_q <= low_cnt_q + CW'(1);
      end else begin
         ext_rst_q <= 1'h1;
      end
   end

   assign in_reset = ext_rst_q || (por_cnt_q != PW'(POR_CYC));

   // Open drain: only ever drives low, enable high while driving
   always_ff @(posedge clock) begin
      if (rst) begin
         rst_pin_o <= 1'h0;
         rst_pin_oe <= 1'h1;
         dev_reset <= 1'h1;
      end else begin
         rst_pin_o <= 1'h0;
         rst_pin_oe <= (por_cnt_q != PW'(POR_CYC));
         dev_reset <= in_reset;
      end
   end

   // Bus power sense
   always_ff @(posedge clock) begin
      if (rst) begin
         attached <= 1'h0;
      end else begin
         attached <= pins.sync[1];
      end
   end

   // Link state; losing bus power needs a fresh configuration
   always_ff @(posedge clock) begin
      if (rst || in_reset) begin
         state_q <= USP_UNCONF;
      end else if (!pins.sync[1]) begin
         state_q <= USP_UNCONF;
      end else if (ev_bus_reset) begin
         // Bus reset ends suspend with outputs released; only a device
         // reset or loss of bus power brings back the assertion that waits for configuration
         if (state_q != USP_UNCONF) begin
            state_q <= USP_ACTIVE;
         end
      end else begin
         unique case (state_q)
            USP_UNCONF: begin
               if (ev_configured) begin
                  state_q <= USP_ACTIVE;
               end
            end
            USP_ACTIVE: begin
               if (ev_suspend) begin
                  state_q <= USP_SUSP;
               end
            end
            USP_SUSP: begin
               if (ev_resume) begin
                  state_q <= USP_ACTIVE;
               end
            end
            default: state_q <= USP_UNCONF;
         endcase
      end
   end

   // Suspend pins; during reset both float high (enable off)
   always_ff @(posedge clock) begin
      if (rst || in_reset) begin
         suspend <= 1'h1;
         suspend_n <= 1'h1;
         suspend_oe <= 1'h0;
      end else begin
         suspend <= (state_q != USP_ACTIVE);
         suspend_n <= (state_q == USP_ACTIVE);
         suspend_oe <= 1'h1;
      end
   end

   // Modem status, reported active high inside
   always_ff @(posedge clock) begin
      if (rst) begin
         modem_status <= '0;
      end else begin
         modem_status <= ~pins.sync[5:2];
      end
   end

   // Modem control and serial lines; engine carries the data
   always_ff @(posedge clock) begin
      if (rst || in_reset) begin
         rts_n_o <= MODEM_OUT_RST;
         dtr_n_o <= MODEM_OUT_RST;
         txd_o <= TXD_IDLE;
         rx_bit <= TXD_IDLE;
      end else begin
         rts_n_o <= ~rts_req;
         dtr_n_o <= ~dtr_req;
         txd_o <= tx_bit;
         rx_bit <= pins.sync[6];
      end
   end

   // GPIO: direction bit one makes a pin an output
   always_ff @(posedge clock) begin
      if (rst || in_reset) begin
         gpio_o <= '0;
         gpio_oe <= '0;
         gpio_rd <= '0;
      end else begin
         gpio_o <= gpio_wr;
         gpio_oe <= gpio_dir;
         gpio_rd <= pins.sync[SW-1:7];
      end
   end

   // Checks
   property p_complement;
      @(posedge clock) disable iff (rst)
         suspend_oe |-> (suspend != suspend_n);
   endproperty
   a_complement: assert property (p_complement)
      else $error("suspend outputs not complementary");

   property p_enter;
      @(posedge clock) disable iff (rst)
         (state_q == USP_ACTIVE && ev_suspend && !in_reset && !ev_bus_reset
          && pins.sync[1]) |=> ##1 (suspend && !suspend_n);
   endproperty
   a_enter: assert property (p_enter)
      else $error("suspend not entered");

   property p_exit;
      @(posedge clock) disable iff (rst)
         (state_q == USP_SUSP && ev_resume && !in_reset && !ev_bus_reset
          && pins.sync[1]) |=> ##1 (!suspend && suspend_n);
   endproperty
   a_exit: assert property (p_exit)
      else $error("suspend not left on resume");

   property p_bus_exit;
      @(posedge clock) disable iff (rst)
         (state_q == USP_SUSP && ev_bus_reset && !in_reset && pins.sync[1])
            |=> ##1 (!suspend && suspend_n);
   endproperty
   a_bus_exit: assert property (p_bus_exit)
      else $error("suspend not left on bus reset");

   property p_float;
      @(posedge clock) disable iff (rst)
         in_reset |=> (suspend && suspend_n && !suspend_oe);
   endproperty
   a_float: assert property (p_float)
      else $error("suspend outputs not floating in reset");

   property p_unconf;
      @(posedge clock) disable iff (rst)
         (state_q == USP_UNCONF)
            |=> (suspend && (!suspend_n || !suspend_oe));
   endproperty
   a_unconf: assert property (p_unconf)
      else $error("suspend not asserted before configuration");

   property p_modem;
      @(posedge clock) disable iff (rst)
         !in_reset |=> (rts_n_o == !$past(rts_req));
   endproperty
   a_modem: assert property (p_modem)
      else $error("rts not active low");

   property p_od;
      @(posedge clock) disable iff (rst)
         rst_pin_oe |-> !rst_pin_o;
   endproperty
   a_od: assert property (p_od)
      else $error("reset pin driven high");

   property p_gpio;
      @(posedge clock) disable iff (rst)
         !in_reset |=> (gpio_oe == $past(gpio_dir));
   endproperty
   a_gpio: assert property (p_gpio)
      else $error("gpio direction not applied");
endmodule

// ===== bench/usp_far_end.sv
/*
 Board side of the bridge: reset pin pull-up and external reset source,
 modem equipment driving the status pins and the receive line.
 Assumes the bridge clock and the usp_pkg constants.
*/
`timescale 1ns/1ps
module usp_far_end
   import usp_pkg::*;
(
   // Clock
   input wire logic clock,
   // Reset pin as the board sees it
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   input wire logic ext_rst,
   output logic rst_pin_i,
   // Equipment requests, active high
   input wire logic [3:0] st,
   input wire logic rxd_v,
   // Pins towards the bridge
   output logic cts_n_i,
   output logic dsr_n_i,
   output logic dcd_n_i,
   output logic ri_n_i,
   output logic rxd_i
);
   int hold_q = 0;

   // A short request is stretched to exactly the least legal pulse,
   // so the bridge is tried at its boundary
   always_ff @(posedge clock) begin
      if (ext_rst) begin
         hold_q <= RST_PULSE_CYC;
      end else if (hold_q != 0) begin
         hold_q <= hold_q - 1;
      end
   end

   // Pull-up wins unless either party sinks the pin
   assign rst_pin_i = ~((rst_pin_oe & ~rst_pin_o) | (hold_q != 0));
   // Equipment asserts its status lines low
   assign {ri_n_i, dcd_n_i, dsr_n_i, cts_n_i} = ~st;
   assign rxd_i = rxd_v;
endmodule

// ===== bench/testbench.sv
/*
 Self-checking bench for the suspend and pin control block.
 Assumes the far-end model in usp_far_end and a 25 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
   import usp_pkg::*;
   logic clock = 0, rst = 1, vbus_i = 1, ext_rst = 0, rxd_v = 1;
   logic rts_req = 0, dtr_req = 0, tx_bit = 1;
   logic [3:0] ev_v = 0, st = 0, gdir = 0, gwr = 0, gin = 0;
   logic rst_pin_i, rst_pin_o, rst_pin_oe, attached, dev_reset;
   logic suspend, suspend_n, suspend_oe, rts_n_o, dtr_n_o, txd_o, rx_bit;
   logic cts_n_i, dsr_n_i, dcd_n_i, ri_n_i, rxd_i;
   logic [3:0] modem_status, gpio_o, gpio_oe, gpio_rd;
   int error_cnt = 0, check_count = 0;

   usp_top dut (.clock(clock), .rst(rst), .rst_pin_i(rst_pin_i),
      .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .vbus_i(vbus_i),
      .attached(attached), .ev_suspend(ev_v[0]), .ev_resume(ev_v[1]),
      .ev_bus_reset(ev_v[2]), .ev_configured(ev_v[3]),
      .dev_reset(dev_reset), .suspend(suspend), .suspend_n(suspend_n),
      .suspend_oe(suspend_oe), .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i),
      .dcd_n_i(dcd_n_i), .ri_n_i(ri_n_i), .modem_status(modem_status),
      .rts_req(rts_req), .dtr_req(dtr_req), .rts_n_o(rts_n_o),
      .dtr_n_o(dtr_n_o), .tx_bit(tx_bit), .rxd_i(rxd_i), .txd_o(txd_o),
      .rx_bit(rx_bit), .gpio_dir(gdir), .gpio_wr(gwr), .gpio_i(gin),
      .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_rd(gpio_rd));
   usp_far_end far (.clock(clock), .rst_pin_o(rst_pin_o),
      .rst_pin_oe(rst_pin_oe), .ext_rst(ext_rst), .rst_pin_i(rst_pin_i),
      .st(st), .rxd_v(rxd_v), .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i),
      .dcd_n_i(dcd_n_i), .ri_n_i(ri_n_i), .rxd_i(rxd_i));

   // Clock, 40 ns period
   initial begin
      forever #20 clock = ~clock;
   end

   task automatic test_done;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One-cycle event, then the two-edge answer time and a settle
   task automatic pulse(input logic [3:0] m);
      @(posedge clock) ev_v <= m;
      @(posedge clock) ev_v <= 4'h0;
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask

   // Bounded wait on the internal reset flag
   task automatic wait_rst(input logic want, input int lim);
      for (int n = 0; n < lim && dev_reset !== want; n++) @(negedge clock);
   endtask

   task automatic t_reset;
      repeat (4) @(negedge clock);
      `CHK({suspend_oe, suspend, suspend_n}, 3'h3)
      `CHK({rst_pin_oe, rst_pin_o}, 2'h2)
      @(posedge clock) rst <= 0;
      wait_rst(1'h0, POR_CYC + 20);
      repeat (2) @(negedge clock);
      `CHK({dev_reset, rst_pin_oe, attached}, 3'h1)
      `CHK({suspend_oe, suspend, suspend_n}, 3'h6)
   endtask

   // Configure, refused resume, suspend, resume, suspend again, bus reset
   task automatic t_susp;
      pulse(4'h8);
      `CHK({suspend, suspend_n}, 2'h1)
      pulse(4'h2);
      `CHK({suspend, suspend_n}, 2'h1)
      pulse(4'h1);
      `CHK({suspend, suspend_n}, 2'h2)
      pulse(4'h2);
      `CHK({suspend, suspend_n}, 2'h1)
      pulse(4'h1);
      pulse(4'h4);
      `CHK({suspend, suspend_n}, 2'h1)
   endtask

   task automatic t_vbus;
      @(posedge clock) vbus_i <= 0;
      repeat (5) @(negedge clock);
      `CHK(attached, 1'h0)
      @(posedge clock) vbus_i <= 1;
      repeat (5) @(negedge clock);
      `CHK(attached, 1'h1)
      pulse(4'h1);
      `CHK({suspend, suspend_n}, 2'h2)
      pulse(4'h4);
      `CHK({suspend, suspend_n}, 2'h2)
   endtask

   task automatic t_lines;
      logic [3:0] v;
      for (int i = 0; i < 16; i++) begin
         v = i[3:0];
         @(posedge clock);
         st <= v;
         {rts_req, dtr_req, tx_bit, rxd_v} <= v;
         gdir <= v;
         gwr <= ~v;
         gin <= v ^ 4'h5;
         repeat (4) @(posedge clock);
         @(negedge clock);
         `CHK(modem_status, v)
         `CHK({rts_n_o, dtr_n_o}, ~v[3:2])
         `CHK({txd_o, rx_bit}, v[1:0])
         `CHK(gpio_oe, v)
         `CHK(gpio_o, ~v)
         `CHK(gpio_rd & ~v, (v ^ 4'h5) & ~v)
      end
   endtask

   // Pin reset while suspended: float, then back to unconfigured
   task automatic t_extrst;
      pulse(4'h8);
      pulse(4'h1);
      @(posedge clock) ext_rst <= 1;
      @(posedge clock) ext_rst <= 0;
      wait_rst(1'h1, RST_PULSE_CYC + 20);
      `CHK({dev_reset, suspend_oe, suspend, suspend_n}, 4'hb)
      wait_rst(1'h0, RST_PULSE_CYC + POR_CYC + 60);
      repeat (2) @(negedge clock);
      `CHK({dev_reset, suspend_oe, suspend, suspend_n}, 4'h6)
      pulse(4'h8);
      `CHK({suspend, suspend_n}, 2'h1)
   endtask

   // Main sequence
   initial begin
      t_reset();
      t_susp();
      t_vbus();
      t_lines();
      t_extrst();
      test_done();
   end

   // Watchdog, well past the expected run of about 600 cycles
   initial begin
      #(40 * 8000);
      error_cnt++;
      test_done();
   end
endmodule
